// ==== hdl/fpm_ctrl.sv ====
/*
 * Protection and modulation-mode control for a primary-side flyback LED
 * controller: gate timing, valley start, off-time extension, mode choice
 * and fault latching.
 * Assumes digitised comparator levels from the analog front end, on/off
 * targets computed elsewhere, and a brown-out reset that follows
 * fault_shutdown_o discharging the supply.
 */
`timescale 1ns/10ps
// How it works
// R1: Over-temperature mode enables pin current source
// R2: Over-voltage mode enables pin pulldown resistance
// R3: Sample sense pin in window's last cycle
// R4: Temperature fault below 1 V, 1.2 V starting
// R5: Sense pin over-voltage fault above 1 V
// R6: Aux above maximum threshold raises over-voltage
// R7: Current above 1.1 V ends pulse at once
// R8: Retry normal pulse next cycle after cutoff
// R9: Aux below 0.22 V raises short fault
// R10: Any pin short leads to protection
// R11: Constant voltage between nominal and maximum
// R12: Light load in CV selects pulse frequency
// R13: Width modulation stays within 30-130 kHz
// R14: Off-time extends until aux falling edge
// R15: Off-time extension capped at 75 us
// R16: Load under 10 percent enters PFM
// R17: PFM on-time from line, off from load
// R18: Load rising returns PFM to width modulation
// R19: Non-peak faults force brown-out and restart
// R20: Constant current below nominal aux level
// R21: New cycle starts at detected valley
// R22: Synchronise inputs; faults hold gate low
// R23: Select alternates on each measurement window
module fpm_ctrl #(
	parameter int PERIOD_MAX = fpm_pkg::PERIOD_MAX_CYC,
	parameter int RESET_MAX  = fpm_pkg::RESET_MAX_CYC,
	parameter int MEAS_WIN   = fpm_pkg::MEAS_WIN_CYCLES
) (
	input  wire logic                        core_clk_i,
	input  wire logic                        srst_i,
	input  wire fpm_pkg::fpm_cmp_t           cmp_i,
	input  wire logic                        soft_start_done_i,
	input  wire logic                        light_load_i,
	input  wire logic [fpm_pkg::TIME_W-1:0]  pwm_on_cyc_i,
	input  wire logic [fpm_pkg::TIME_W-1:0]  pfm_on_cyc_i,
	input  wire logic [fpm_pkg::TIME_W-1:0]  pfm_off_cyc_i,
	output logic                             gate_o,
	output logic                             sense_pin_select_o,
	output logic                             current_source_en_o,
	output logic                             sense_pin_pulldown_o,
	output logic                             peak_current_limit_o,
	output logic                             fault_shutdown_o,
	output fpm_pkg::fpm_fault_t              fault_o,
	output logic                             cv_mode_o,
	output logic                             pfm_mode_o
);

	localparam logic [fpm_pkg::TIME_W-1:0] PMIN =
		fpm_pkg::TIME_W'(fpm_pkg::PERIOD_MIN_CYC);
	localparam logic [fpm_pkg::TIME_W-1:0] PMAX =
		fpm_pkg::TIME_W'(PERIOD_MAX);
	localparam logic [fpm_pkg::TIME_W-1:0] RMAX =
		fpm_pkg::TIME_W'(RESET_MAX);
	localparam logic [7:0] WLAST = 8'(MEAS_WIN - 1);

	// ---------------------------------------------------------------
	// Input synchronisation
	// ---------------------------------------------------------------
	fpm_pkg::fpm_cmp_t cmp_s;
	logic [fpm_pkg::SYNC_W-1:0] cmp_raw;

	assign cmp_raw = cmp_i;

	fpm_sync #(
		.W (fpm_pkg::SYNC_W)
	) u_sync (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.async_i    (cmp_raw),    // R22
		.sync_o     (cmp_s)
	);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	fpm_pkg::fpm_state_t         state_reg, state_next;
	logic [fpm_pkg::TIME_W-1:0]  on_cnt_reg, on_cnt_next;
	logic [fpm_pkg::TIME_W-1:0]  per_cnt_reg, per_cnt_next;
	logic [fpm_pkg::TIME_W-1:0]  rst_cnt_reg, rst_cnt_next;
	logic [7:0]                  win_cnt_reg, win_cnt_next;
	logic                        gate_reg, gate_next;
	logic                        sel_reg, sel_next;
	logic                        pull_reg, pull_next;
	logic                        pcl_reg, pcl_next;
	logic                        aux_prev_reg, aux_prev_next;
	logic                        hi_max_reg, hi_max_next;
	logic                        hi_nom_reg, hi_nom_next;
	logic                        lo_short_reg, lo_short_next;
	logic                        cv_reg, cv_next;
	logic                        pfm_reg, pfm_next;
	fpm_pkg::fpm_fault_t         fault_reg, fault_next;
	logic                        shut_reg, shut_next;

	logic                        any_fault;
	logic                        aux_fall;
	logic [fpm_pkg::TIME_W-1:0]  on_target;
	logic                        off_done;

	// ---------------------------------------------------------------
	// Regulation mode
	// ---------------------------------------------------------------
	always_comb begin
		cv_next  = cv_reg;
		pfm_next = pfm_reg;
		// Levels taken at the knee, where the diode drop is small
		if (aux_fall) begin
			cv_next = hi_nom_reg && !hi_max_reg;    // R11 R20
		end
		if (!cv_reg || !soft_start_done_i) begin
			pfm_next = 1'b0;                        // R12
		end else begin
			pfm_next = light_load_i;                // R12 R16 R18
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cv_reg  <= 1'b0;
			pfm_reg <= 1'b0;
		end else begin
			cv_reg  <= cv_next;
			pfm_reg <= pfm_next;
		end
	end

	// ---------------------------------------------------------------
	// Switching cycle
	// ---------------------------------------------------------------
	assign aux_fall  = aux_prev_reg && !cmp_s.aux_high;
	assign on_target = pfm_reg ? pfm_on_cyc_i : pwm_on_cyc_i;    // R17
	assign any_fault = |fault_reg;
	// PFM stretches the period from load; PWM only keeps the lower bound
	assign off_done  = pfm_reg ? (per_cnt_reg >= on_cnt_reg + pfm_off_cyc_i)
	                           : (per_cnt_reg >= PMIN);          // R13 R17

	always_comb begin
		state_next    = state_reg;
		on_cnt_next   = on_cnt_reg;
		per_cnt_next  = per_cnt_reg;
		rst_cnt_next  = rst_cnt_reg;
		gate_next     = 1'b0;
		pcl_next      = 1'b0;
		aux_prev_next = cmp_s.aux_high;
		hi_max_next   = hi_max_reg;
		hi_nom_next   = hi_nom_reg;
		lo_short_next = lo_short_reg;
		if (per_cnt_reg != '1) begin
			per_cnt_next = per_cnt_reg + 1'b1;
		end
		case (state_reg)
			fpm_pkg::ST_IDLE: begin
				if (soft_start_done_i && !any_fault) begin
					state_next   = fpm_pkg::ST_ON;
					gate_next    = 1'b1;
					on_cnt_next  = '0;
					per_cnt_next = '0;
				end
			end
			fpm_pkg::ST_ON: begin
				on_cnt_next = on_cnt_reg + 1'b1;
				if (any_fault) begin
					state_next = fpm_pkg::ST_IDLE;           // R22
				end else if (cmp_s.isense_above_limit) begin
					state_next   = fpm_pkg::ST_RESET;        // R7
					pcl_next     = 1'b1;
					rst_cnt_next = '0;
				end else if (on_cnt_reg + 1'b1 >= on_target) begin
					state_next   = fpm_pkg::ST_RESET;
					rst_cnt_next = '0;
				end else begin
					gate_next = 1'b1;
				end
			end
			fpm_pkg::ST_RESET: begin
				rst_cnt_next = rst_cnt_reg + 1'b1;
				// Track the plateau so the knee level is held on the edge
				if (cmp_s.aux_high) begin
					hi_max_next   = cmp_s.aux_above_max;
					hi_nom_next   = cmp_s.aux_above_nom;
					lo_short_next = cmp_s.aux_below_short;
				end
				if (any_fault) begin
					state_next = fpm_pkg::ST_IDLE;
				end else if (aux_fall) begin
					state_next = fpm_pkg::ST_WAIT;           // R14
				end else if (rst_cnt_reg >= RMAX - 1'b1) begin
					state_next = fpm_pkg::ST_WAIT;           // R15
				end
			end
			fpm_pkg::ST_WAIT: begin
				if (any_fault) begin
					state_next = fpm_pkg::ST_IDLE;
				end else if ((cmp_s.aux_valley && off_done) ||
				             (!pfm_reg && per_cnt_reg >= PMAX - 1'b1)) begin
					// Regular pulse after a cutoff, cut again if needed
					state_next   = fpm_pkg::ST_ON;           // R21 R13 R8
					gate_next    = 1'b1;
					on_cnt_next  = '0;
					per_cnt_next = '0;
				end
			end
			default: begin
				state_next = fpm_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_reg    <= fpm_pkg::ST_IDLE;
			on_cnt_reg   <= '0;
			per_cnt_reg  <= '0;
			rst_cnt_reg  <= '0;
			gate_reg     <= 1'b0;
			pcl_reg      <= 1'b0;
			aux_prev_reg <= 1'b0;
			hi_max_reg   <= 1'b0;
			hi_nom_reg   <= 1'b0;
			lo_short_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			on_cnt_reg   <= on_cnt_next;
			per_cnt_reg  <= per_cnt_next;
			rst_cnt_reg  <= rst_cnt_next;
			gate_reg     <= gate_next;
			pcl_reg      <= pcl_next;
			aux_prev_reg <= aux_prev_next;
			hi_max_reg   <= hi_max_next;
			hi_nom_reg   <= hi_nom_next;
			lo_short_reg <= lo_short_next;
		end
	end

	// ---------------------------------------------------------------
	// Shutdown-sense measurement window
	// ---------------------------------------------------------------
	logic last_turnoff;

	// Sample as the last gate pulse of the window ends: settled by then
	assign last_turnoff = (state_reg == fpm_pkg::ST_ON) &&
	                      (state_next != fpm_pkg::ST_ON) &&
	                      (win_cnt_reg == WLAST);

	always_comb begin
		win_cnt_next = win_cnt_reg;
		sel_next     = sel_reg;
		if (state_reg != fpm_pkg::ST_ON && state_next == fpm_pkg::ST_ON) begin
			if (win_cnt_reg == WLAST) begin
				win_cnt_next = '0;
				sel_next     = !sel_reg;                   // R23
			end else begin
				win_cnt_next = win_cnt_reg + 1'b1;
			end
		end
		// Registered so the pin control leaves a flip-flop directly
		pull_next = !sel_next;                             // R2
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			win_cnt_reg <= '0;
			sel_reg     <= fpm_pkg::SELECT_RST;
			pull_reg    <= !fpm_pkg::SELECT_RST;
		end else begin
			win_cnt_reg <= win_cnt_next;
			sel_reg     <= sel_next;
			pull_reg    <= pull_next;
		end
	end

	// ---------------------------------------------------------------
	// Fault latching
	// ---------------------------------------------------------------
	// Faults stay latched until the brown-out reset clears them
	always_comb begin
		fault_next = fault_reg;
		if (last_turnoff && sel_reg) begin
			if (soft_start_done_i ? !cmp_s.sense_pin_above_1v
			                      : !cmp_s.sense_pin_above_1v2) begin
				fault_next.over_temp = 1'b1;               // R3 R4
			end
		end
		if (last_turnoff && !sel_reg && cmp_s.sense_pin_above_1v) begin
			fault_next.sense_pin_ovp = 1'b1;               // R3 R5
		end
		if (aux_fall && hi_max_reg) begin
			fault_next.over_voltage = 1'b1;                // R6
		end
		if (aux_fall && lo_short_reg && !cv_reg) begin
			fault_next.short_circuit = 1'b1;               // R9
		end
		if (|cmp_s.pin_short) begin
			fault_next.pin_short = 1'b1;                   // R10
		end
		shut_next = |fault_next;                           // R19
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			fault_reg <= '0;
			shut_reg  <= 1'b0;
		end else begin
			fault_reg <= fault_next;
			shut_reg  <= shut_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign gate_o               = gate_reg;                // R22
	assign sense_pin_select_o   = sel_reg;
	assign current_source_en_o  = sel_reg;                 // R1
	assign sense_pin_pulldown_o = pull_reg;                // R2
	assign peak_current_limit_o = pcl_reg;
	assign fault_shutdown_o     = shut_reg;
	assign fault_o              = fault_reg;
	assign cv_mode_o            = cv_reg;
	assign pfm_mode_o           = pfm_reg;

endmodule

// ==== hdl/fpm_pkg.sv ====
/*
 * Shared constants and carrier types for the flyback protection and
 * modulation-mode control block.
 * Assumes a single 125 MHz core clock and a synchronous, active-high reset
 * that is pulsed by the supply brown-out detector.
 */
package fpm_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ          = 125000;
	localparam int FSW_MAX_KHZ      = 130;
	localparam int FSW_MIN_KHZ      = 30;
	localparam int RESET_MAX_US     = 75;
	// Shortest period rounds up, longest period rounds down
	localparam int PERIOD_MIN_CYC   = (CLK_KHZ + FSW_MAX_KHZ - 1) / FSW_MAX_KHZ;
	localparam int PERIOD_MAX_CYC   = CLK_KHZ / FSW_MIN_KHZ;
	localparam int RESET_MAX_CYC    = RESET_MAX_US * CLK_KHZ / 1000;
	localparam int MEAS_WIN_CYCLES  = 8;
	localparam int TIME_W           = 16;
	localparam int SYNC_W           = 13;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic SELECT_RST     = 1'b1;

	// ---------------------------------------------------------------
	// Comparator results as they arrive from the analog front end
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       sense_pin_above_1v;
		logic       sense_pin_above_1v2;
		logic       aux_above_max;
		logic       aux_above_nom;
		logic       aux_below_short;
		logic       aux_high;
		logic       aux_valley;
		logic       isense_above_limit;
		logic [4:0] pin_short;
	} fpm_cmp_t;

	typedef struct packed {
		logic over_temp;
		logic sense_pin_ovp;
		logic over_voltage;
		logic short_circuit;
		logic pin_short;
	} fpm_fault_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ON    = 2'b01,
		ST_RESET = 2'b10,
		ST_WAIT  = 2'b11
	} fpm_state_t;

endpackage

// ==== hdl/fpm_sync.sv ====
/*
 * Two-flop synchroniser bank for asynchronous comparator levels.
 * Assumes every bit is an independent level; no bus coherence is given.
 */
`timescale 1ns/10ps
module fpm_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = async_i;
		sync_next = meta_reg;
	end

	// First stage feeds only the second stage
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;

endmodule

// ==== tb/fpm_ctrl_sva.sv ====
/*
 * Port checker for fpm_ctrl, bound into every instance of it.
 * Assumes the single core clock and the synchronous active-high reset.
 */
`timescale 1ns/10ps
module fpm_ctrl_sva #(
	parameter int PERIOD_MAX = 4166
) (
	input  wire logic                core_clk_i,
	input  wire logic                srst_i,
	input  wire fpm_pkg::fpm_cmp_t   cmp_i,
	input  wire logic                soft_start_done_i,
	input  wire logic                light_load_i,
	input  wire logic                gate_o,
	input  wire logic                sense_pin_select_o,
	input  wire logic                current_source_en_o,
	input  wire logic                sense_pin_pulldown_o,
	input  wire logic                peak_current_limit_o,
	input  wire logic                fault_shutdown_o,
	input  wire fpm_pkg::fpm_fault_t fault_o,
	input  wire logic                cv_mode_o,
	input  wire logic                pfm_mode_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// ---------------------------------------------------------------
	// Rise-to-rise period counter, zero until the first pulse
	// ---------------------------------------------------------------
	logic [15:0] per_reg;
	logic [15:0] per_next;
	logic        gate_d_reg;
	always_comb begin
		per_next = per_reg + 16'(per_reg != 16'h0000);
		if (gate_o && !gate_d_reg) begin
			per_next = 16'h0001;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			per_reg    <= 16'h0000;
			gate_d_reg <= 1'b0;
		end else begin
			per_reg    <= per_next;
			gate_d_reg <= gate_o;
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	property p_sense_src;
		current_source_en_o == sense_pin_select_o &&
			sense_pin_pulldown_o == !sense_pin_select_o;
	endproperty
	a_sense_src: assert property (p_sense_src)
		else $error("sense pin source does not follow select");
	property p_fault_gate;
		fault_shutdown_o && $past(fault_shutdown_o) |-> !gate_o;
	endproperty
	a_fault_gate: assert property (p_fault_gate)
		else $error("gate driven while fault pending");
	property p_fault_shut;
		fault_o != 5'h00 |-> fault_shutdown_o;
	endproperty
	a_fault_shut: assert property (p_fault_shut)
		else $error("fault latched without shutdown");
	property p_sticky;
		($past(fault_o) & ~fault_o) == 5'h00;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("fault cleared without reset");
	property p_pcl_pulse;
		peak_current_limit_o |=> !peak_current_limit_o;
	endproperty
	a_pcl_pulse: assert property (p_pcl_pulse)
		else $error("peak limit pulse longer than one cycle");
	property p_pcl_cause;
		$rose(peak_current_limit_o) |-> $past(cmp_i.isense_above_limit, 2)
			|| $past(cmp_i.isense_above_limit, 3);
	endproperty
	a_pcl_cause: assert property (p_pcl_cause)
		else $error("peak limit without current comparator");
	property p_pfm;
		pfm_mode_o == $past(cv_mode_o && soft_start_done_i && light_load_i);
	endproperty
	a_pfm: assert property (p_pfm)
		else $error("pfm mode does not follow cv and light load");
	property p_short_cc;
		$rose(fault_o.short_circuit) |-> !cv_mode_o;
	endproperty
	a_short_cc: assert property (p_short_cc)
		else $error("short fault raised in cv mode");
	property p_pin_short;
		cmp_i.pin_short != 5'h00 |-> ##[1:3] fault_o.pin_short;
	endproperty
	a_pin_short: assert property (p_pin_short)
		else $error("pin short not latched in time");
	property p_sel_turn;
		$changed(sense_pin_select_o) |-> ##[0:1] gate_o;
	endproperty
	a_sel_turn: assert property (p_sel_turn)
		else $error("select changed away from a pulse start");
	// Slack of one cycle on each bound: the counter starts at the rise
	property p_period;
		$rose(gate_o) && per_reg != 16'h0000 && !pfm_mode_o &&
			!$past(pfm_mode_o) |->
			per_reg >= 16'(fpm_pkg::PERIOD_MIN_CYC - 1) &&
			per_reg <= 16'(PERIOD_MAX + 1);
	endproperty
	a_period: assert property (p_period)
		else $error("pwm period out of range");
	c_pcl: cover property (peak_current_limit_o);
	c_pfm: cover property (pfm_mode_o);
	c_shut: cover property ($rose(fault_shutdown_o));
endmodule

bind fpm_ctrl fpm_ctrl_sva #(.PERIOD_MAX(PERIOD_MAX)) i_fpm_ctrl_sva (
	.core_clk_i, .srst_i, .cmp_i, .soft_start_done_i, .light_load_i,
	.gate_o, .sense_pin_select_o, .current_source_en_o,
	.sense_pin_pulldown_o, .peak_current_limit_o, .fault_shutdown_o,
	.fault_o, .cv_mode_o, .pfm_mode_o
);

// ==== tb/fpm_stage_model.sv ====
/*
 * Behavioural flyback stage and sense network facing fpm_ctrl.
 * Assumes its gate and sense-pin controls; levels come from the bench.
 */
`timescale 1ns/10ps
module fpm_stage_model (
	input  wire logic         core_clk_i,
	input  wire logic         gate_i,
	input  wire logic         cur_src_i,
	input  wire logic         pulldown_i,
	input  wire logic [1:0]   aux_lvl_i,
	input  wire logic [15:0]  plateau_i,
	input  wire logic [15:0]  ilim_i,
	input  wire logic         ntc_ok_i,
	input  wire logic         sd_ov_i,
	input  wire logic [4:0]   pin_short_i,
	output fpm_pkg::fpm_cmp_t cmp_o
);
	// ---------------------------------------------------------------
	// Aux level code: 0 shorted, 1 below nominal, 2 regulating, 3 over
	// ---------------------------------------------------------------
	logic [15:0] on_cnt  = 16'h0000;
	logic [15:0] off_cnt = 16'h0000;
	logic        aux_hi;
	always @(posedge core_clk_i) begin
		on_cnt  <= gate_i ? on_cnt + 16'h0001 : 16'h0000;
		off_cnt <= gate_i ? 16'h0000 : off_cnt + 16'(off_cnt != 16'hffff);
	end
	// Plateau lasts while the secondary conducts; ringing only after it
	assign aux_hi = !gate_i && off_cnt < plateau_i;
	always_comb begin
		cmp_o.sense_pin_above_1v  = cur_src_i ? ntc_ok_i : pulldown_i & sd_ov_i;
		cmp_o.sense_pin_above_1v2 = cur_src_i & ntc_ok_i;
		cmp_o.aux_above_max       = aux_hi && aux_lvl_i == 2'h3;
		cmp_o.aux_above_nom       = aux_hi && aux_lvl_i >= 2'h2;
		cmp_o.aux_below_short     = aux_hi && aux_lvl_i == 2'h0;
		cmp_o.aux_high            = aux_hi;
		cmp_o.aux_valley          = !gate_i && !aux_hi && &off_cnt[4:0];
		cmp_o.isense_above_limit  = gate_i && ilim_i != 16'h0000 &&
			on_cnt >= ilim_i;
		cmp_o.pin_short           = pin_short_i;
	end
endmodule

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for fpm_ctrl with a behavioural power stage.
 * Assumes shortened period and reset limits and a two-pulse window.
 */
`timescale 1ns/10ps
module testbench;
	logic              core_clk_i = 1'b0;
	logic              srst_i, ss_done, light, gate_o, sel, csrc, pull;
	logic              pcl, shut, cv, pfm, ntc_ok, sd_ov;
	logic [15:0]       pwm_on, pfm_on, pfm_off, plateau, ilim;
	logic [1:0]        aux_lvl;
	logic [4:0]        pin_short;
	fpm_pkg::fpm_cmp_t   cmp;
	fpm_pkg::fpm_fault_t fault;
	int                mismatches = 0;
	int                n_checks = 0;
	int                pcl_n = 0;
	int                on, off;
	always #4 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (pcl === 1'b1) pcl_n++;
	fpm_ctrl #(.PERIOD_MAX(3000), .RESET_MAX(1500), .MEAS_WIN(2)) i_fpm_ctrl (
		.core_clk_i(core_clk_i), .srst_i(srst_i), .cmp_i(cmp),
		.soft_start_done_i(ss_done), .light_load_i(light),
		.pwm_on_cyc_i(pwm_on), .pfm_on_cyc_i(pfm_on),
		.pfm_off_cyc_i(pfm_off), .gate_o(gate_o),
		.sense_pin_select_o(sel), .current_source_en_o(csrc),
		.sense_pin_pulldown_o(pull), .peak_current_limit_o(pcl),
		.fault_shutdown_o(shut), .fault_o(fault), .cv_mode_o(cv),
		.pfm_mode_o(pfm));
	fpm_stage_model i_fpm_stage_model (
		.core_clk_i(core_clk_i), .gate_i(gate_o), .cur_src_i(csrc),
		.pulldown_i(pull), .aux_lvl_i(aux_lvl), .plateau_i(plateau),
		.ilim_i(ilim), .ntc_ok_i(ntc_ok), .sd_ov_i(sd_ov),
		.pin_short_i(pin_short), .cmp_o(cmp));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wait_gate(logic lvl, output int n);
		n = 0;
		while (gate_o !== lvl) begin
			@(negedge core_clk_i);
			n++;
			if (n > 9000) begin
				mismatches++;
				print_verdict();
			end
		end
	endtask
	// Measures the high time of the last of cnt pulses and the low time that follows it
	task automatic pulse(int cnt);
		int n;
		repeat (cnt) begin
			wait_gate(1'b1, n);
			wait_gate(1'b0, on);
			wait_gate(1'b1, off);
		end
	endtask
	task automatic restart(logic [1:0] lvl);
		@(posedge core_clk_i);
		srst_i <= 1'b1;
		aux_lvl <= lvl;
		light <= 1'b0;
		ntc_ok <= 1'b1;
		sd_ov <= 1'b0;
		pin_short <= 5'h00;
		repeat (6) @(posedge core_clk_i);
		srst_i <= 1'b0;
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_cc;
		restart(2'h1);
		light <= 1'b1;
		pulse(3);
		check("on_time", 16'(on), pwm_on);
		check("cv_mode", 16'(cv), 16'h0000);
		check("pfm_mode", 16'(pfm), 16'h0000);
	endtask
	task automatic t_cv_pfm;
		restart(2'h2);
		light <= 1'b1;
		pulse(4);
		check("cv_mode", 16'(cv), 16'h0001);
		check("pfm_mode", 16'(pfm), 16'h0001);
		check("pfm_on", 16'(on), pfm_on);
		check("pfm_off", 16'(off >= pfm_off), 16'h0001);
		@(posedge core_clk_i);
		ss_done <= 1'b0;
		repeat (2) @(negedge core_clk_i);
		check("pfm_ss", 16'(pfm), 16'h0000);
		@(posedge core_clk_i);
		ss_done <= 1'b1;
		light <= 1'b0;
		pulse(3);
		check("pfm_mode", 16'(pfm), 16'h0000);
		check("on_time", 16'(on), pwm_on);
	endtask
	task automatic t_peak;
		int n0;
		restart(2'h1);
		ilim <= 16'h0005;
		pulse(1);
		n0 = pcl_n;
		pulse(2);
		check("cut_on", 16'(on < 16), 16'h0001);
		check("cut_count", 16'(pcl_n - n0), 16'h0002);
		ilim <= 16'h0000;
		pulse(2);
		check("on_time", 16'(on), pwm_on);
	endtask
	task automatic t_ext;
		restart(2'h1);
		plateau <= 16'h04b0;
		pulse(3);
		check("ext_off", 16'(off >= 1200), 16'h0001);
		plateau <= 16'h0028;
	endtask
	// Kinds 0..3 set one fault source, 4..8 short one pin each
	task automatic t_fault(int k);
		int n;
		int hi;
		restart(k == 2 ? 2'h3 : k == 3 ? 2'h0 : 2'h1);
		ntc_ok <= k != 0;
		sd_ov <= k == 1;
		pin_short <= k > 3 ? 5'h01 << (k - 4) : 5'h00;
		n = 0;
		while (shut !== 1'b1) begin
			@(negedge core_clk_i);
			n++;
			if (n > 20000) begin
				mismatches++;
				print_verdict();
			end
		end
		check("fault", 16'(fault), k > 3 ? 16'h0001 : 16'h0010 >> k);
		hi = 0;
		repeat (1500) begin
			@(negedge core_clk_i);
			hi += int'(gate_o !== 1'b0);
		end
		check("gate_held", 16'(hi), 16'h0000);
	endtask
	initial begin
		srst_i = 1'b1;
		ss_done = 1'b1;
		light = 1'b0;
		pwm_on = 16'h0064;
		pfm_on = 16'h0030;
		pfm_off = 16'h05dc;
		plateau = 16'h0028;
		ilim = 16'h0000;
		aux_lvl = 2'h1;
		ntc_ok = 1'b1;
		sd_ov = 1'b0;
		pin_short = 5'h00;
		t_cc();
		t_cv_pfm();
		t_peak();
		t_ext();
		for (int k = 0; k < 9; k++) begin
			t_fault(k);
		end
		print_verdict();
	end
endmodule
